// ---- rtl/smch_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module smch_buf
    import smch_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = SMCH_BUF_DEPTH
) (
    // System
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg < (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (clk_en && push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- rtl/smch_dte.sv ----
`timescale 1ns/1ps
`default_nettype none
module smch_dte
    import smch_pkg::*;
#(
    parameter int DATA_BITS = 8,
    parameter int BIT_DIV   = 1085,
    parameter int HOLD_CYC  = SMCH_RTS_HOLD_CYC
) (
    // System
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // Software control
    input  wire logic                 term_ready_en,
    input  wire logic                 flow_gate_en,
    // Byte stream in
    input  wire logic [DATA_BITS-1:0] tx_data,
    input  wire logic                 tx_valid,
    output logic                      tx_ready,
    // Modem lines
    input  wire logic                 cts_in,
    input  wire logic                 dsr_in,
    input  wire logic                 dcd_in,
    input  wire logic                 ri_in,
    output logic                      rts_out,
    output logic                      dtr_out,
    output logic                      td_out,
    // Status
    output logic [SMCH_NUM_CTRL-1:0]  line_level,
    output logic [SMCH_NUM_CTRL-1:0]  line_change,
    output logic                      tx_busy
);
    localparam int DW = $clog2(BIT_DIV + 1);
    localparam int BW = $clog2(DATA_BITS + 1);
    localparam int HW = $clog2(HOLD_CYC + 2);

    logic [SMCH_NUM_CTRL-1:0] raw;
    logic [SMCH_NUM_CTRL-1:0] sync1_reg;
    logic [SMCH_NUM_CTRL-1:0] sync2_reg;
    logic [SMCH_NUM_CTRL-1:0] level_reg;
    logic [SMCH_NUM_CTRL-1:0] change_reg;
    logic [DATA_BITS-1:0]     b_data;
    logic                     b_valid;
    logic                     b_ready;
    logic                     in_ready;
    smch_tx_state_t           state_reg;
    logic [DW-1:0]            div_reg;
    logic [BW-1:0]            bit_reg;
    logic [DATA_BITS-1:0]     shift_reg;
    logic [HW-1:0]            hold_reg;
    logic                     rts_reg;
    logic                     dtr_reg;
    logic                     td_reg;
    logic                     busy_reg;
    logic                     tx_ready_reg;
    logic                     may_start;
    logic                     bit_tick;
    logic                     push_ok;
    logic                     gate_ok;

    assign raw = {ri_in, dcd_in, dsr_in, cts_in};

    // Inputs are asynchronous to our clock; only sync2 is ever looked at
    genvar gi;
    generate
        for (gi = 0; gi < SMCH_NUM_CTRL; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    sync1_reg[gi]  <= 1'b0;
                    sync2_reg[gi]  <= 1'b0;
                    level_reg[gi]  <= 1'b0;
                    change_reg[gi] <= 1'b0;
                end else if (clk_en) begin
                    sync1_reg[gi]  <= raw[gi];
                    sync2_reg[gi]  <= sync1_reg[gi];
                    level_reg[gi]  <= sync2_reg[gi];
                    change_reg[gi] <= sync2_reg[gi] ^ level_reg[gi];
                end
            end
        end
    endgenerate

    // Buffer keeps words offered while the modem holds off transmission
    smch_buf #(.WIDTH(DATA_BITS), .DEPTH(SMCH_BUF_DEPTH)) u_buf (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_data   (tx_data),
        .in_valid  (push_ok),
        .in_ready  (in_ready),
        .out_data  (b_data),
        .out_valid (b_valid),
        .out_ready (b_ready)
    );

    // Gating may be bypassed for peripherals that leave CTS and DSR open
    assign gate_ok   = !flow_gate_en ||
                       (level_reg[SMCH_IDX_CTS] && level_reg[SMCH_IDX_DSR]);
    // A frame needs DTR and RTS on at once, and CTS and DSR too unless gating is bypassed
    assign may_start = dtr_reg && rts_reg && gate_ok;
    assign b_ready   = (state_reg == SMCH_IDLE) && may_start && b_valid;
    assign bit_tick  = (div_reg == DW'(BIT_DIV - 1));
    // Only words offered while the registered ready is shown enter the buffer
    assign push_ok   = tx_valid && tx_ready_reg;

    // Terminal ready follows software one cycle later
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dtr_reg <= 1'b0;
        end else if (clk_en) begin
            dtr_reg <= term_ready_en;
        end
    end

    // Bit-time divider runs only inside a frame so each start bit is full length
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_reg <= '0;
        end else if (clk_en) begin
            div_reg <= (state_reg == SMCH_IDLE || bit_tick) ? '0 : div_reg + 1'b1;
        end
    end

    // Frame shifter: start bit, data LSB first, one stop bit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= SMCH_IDLE;
            bit_reg   <= '0;
            shift_reg <= '0;
            td_reg    <= SMCH_MARK;
        end else if (clk_en) begin
            case (state_reg)
                SMCH_IDLE: begin
                    td_reg <= SMCH_MARK;
                    if (b_ready) begin
                        shift_reg <= b_data;
                        td_reg    <= ~SMCH_MARK;
                        state_reg <= SMCH_START;
                    end
                end
                SMCH_START: begin
                    if (bit_tick) begin
                        td_reg    <= shift_reg[0];
                        shift_reg <= shift_reg >> 1;
                        bit_reg   <= BW'(1);
                        state_reg <= SMCH_DATA;
                    end
                end
                SMCH_DATA: begin
                    if (bit_tick) begin
                        if (bit_reg == BW'(DATA_BITS)) begin
                            td_reg    <= SMCH_MARK;
                            state_reg <= SMCH_STOP;
                        end else begin
                            td_reg    <= shift_reg[0];
                            shift_reg <= shift_reg >> 1;
                            bit_reg   <= bit_reg + 1'b1;
                        end
                    end
                end
                // Line rests at mark from the stop bit onward
                SMCH_STOP: begin
                    td_reg <= SMCH_MARK;
                    if (bit_tick) begin
                        state_reg <= SMCH_IDLE;
                    end
                end
                default: begin
                    state_reg <= SMCH_IDLE;
                    td_reg    <= SMCH_MARK;
                end
            endcase
        end
    end

    // Request stays up while DTR is on and data waits or a frame runs, then after a hold-off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rts_reg  <= 1'b0;
            hold_reg <= '0;
        end else if (clk_en) begin
            if (dtr_reg && (b_valid || state_reg != SMCH_IDLE)) begin
                rts_reg  <= 1'b1;
                hold_reg <= HW'(HOLD_CYC);
            end else if (hold_reg != '0) begin
                hold_reg <= hold_reg - 1'b1;
            end else begin
                rts_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else if (clk_en) begin
            busy_reg <= (state_reg != SMCH_IDLE) || b_valid;
        end
    end

    // Ready drops for a cycle after each accepted word: in_ready does not yet count
    // that word, so this keeps the registered ready from promising space it lacks
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_ready_reg <= 1'b0;
        end else if (clk_en) begin
            tx_ready_reg <= in_ready && !push_ok;
        end
    end

    // Every output is a flop
    assign rts_out     = rts_reg;
    assign dtr_out     = dtr_reg;
    assign td_out      = td_reg;
    assign line_level  = level_reg;
    assign line_change = change_reg;
    assign tx_busy     = busy_reg;
    // Words are accepted only on tx_valid with this high
    assign tx_ready    = tx_ready_reg;
endmodule
`default_nettype wire

// ---- rtl/smch_pkg.sv ----
// Notes on behaviour
// - Raise request to send when transmit ready
// - Drop request to send when transmission done; the code holds it a further HOLD_CYC cycles first
// - Transmit line idles at mark
// - Start frames only with all four lines asserted; CTS and DSR are checked only while flow_gate_en is set
// - Raise terminal ready when ready for traffic
// - Terminal ready precedes data set ready
package smch_pkg;
    localparam int  SMCH_SYNC_STAGES = 2;
    localparam int  SMCH_NUM_CTRL    = 4;
    localparam int  SMCH_IDX_CTS     = 0;
    localparam int  SMCH_IDX_DSR     = 1;
    localparam int  SMCH_IDX_DCD     = 2;
    localparam int  SMCH_IDX_RI      = 3;
    localparam logic SMCH_MARK       = 1'b1;
    localparam int  SMCH_CLK_MHZ     = 125;
    // Hold-off after the last stop bit before request is dropped
    localparam int  SMCH_RTS_HOLD_NS = 1000;
    localparam int  SMCH_RTS_HOLD_CYC = (SMCH_RTS_HOLD_NS * SMCH_CLK_MHZ + 999) / 1000;
    localparam int  SMCH_BUF_DEPTH   = 2;
    typedef enum logic [1:0] {SMCH_IDLE, SMCH_START, SMCH_DATA, SMCH_STOP} smch_tx_state_t;
endpackage

// ---- testbench/smch_dce_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module smch_dce_model #(
    parameter int BIT_DIV = 4
) (
    // System
    input wire logic       clock,
    input wire logic       sys_rst,
    // From the terminal
    input wire logic       rts,
    input wire logic       dtr,
    input wire logic       td,
    // Scenario knobs
    input wire logic       carrier,
    input wire logic       half_duplex,
    input wire logic       link_down,
    input wire logic [3:0] cts_dly,
    input wire logic       null_modem,
    // To the terminal
    output logic           cts,
    output logic           dsr,
    output logic           dcd,
    output logic           rd
);
    logic [8:0] rx_q[$];
    logic [8:0] b;
    int         cnt;
    always @(posedge clock) begin
        if (sys_rst) begin
            cts <= 1'b0;
            dsr <= 1'b0;
            dcd <= 1'b0;
            rd  <= 1'b1;
            cnt <= 0;
        end else begin
            dsr <= dtr && !link_down;
            dcd <= carrier && !(half_duplex && rts);
            rd  <= 1'b1; // No return traffic, so receive data rests at mark
            if (null_modem) begin
                cts <= rts;
            end else if (rts && dsr && dtr && cnt < cts_dly) begin
                cnt <= cnt + 1;
            end else if (rts && dsr && dtr) begin
                cts <= 1'b1;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end else begin
                cts <= 1'b0;
            end
        end
    end
    // Mid-bit sampling; stop bit lands in bit 8
    initial begin
        forever begin
            @(posedge clock);
            if (!sys_rst && td === 1'b0) begin
                repeat (BIT_DIV / 2) @(posedge clock);
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT_DIV) @(posedge clock);
                    b[i] = td;
                end
                rx_q.push_back(b);
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/smch_dte_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module smch_chk
    import smch_pkg::*;
#(
    parameter int HOLD_CYC = SMCH_RTS_HOLD_CYC
) (
    // System
    input wire logic                     clock,
    input wire logic                     sys_rst,
    // Control
    input wire logic                     term_ready_en,
    input wire logic                     flow_gate_en,
    // Modem lines
    input wire logic                     cts_in,
    input wire logic                     dsr_in,
    input wire logic                     dcd_in,
    input wire logic                     ri_in,
    input wire logic                     rts_out,
    input wire logic                     dtr_out,
    input wire logic                     td_out,
    // Status
    input wire logic [SMCH_NUM_CTRL-1:0] line_level,
    input wire logic [SMCH_NUM_CTRL-1:0] line_change,
    input wire logic                     tx_busy
);
    logic [3:0] ctrl_in;
    int         idle_cnt;
    int         age;
    assign ctrl_in = {ri_in, dcd_in, dsr_in, cts_in};
    // The sync and change-flag checks wait until their look-back lies wholly after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            age <= 0;
        end else if (age < 3) begin
            age <= age + 1;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst || tx_busy || !rts_out) begin
            idle_cnt <= 0;
        end else begin
            idle_cnt <= idle_cnt + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_TD_IDLE: assert property (!tx_busy |-> td_out == SMCH_MARK) else $error("td left idle");
    AST_DTR_FOLLOW: assert property (##1 dtr_out == $past(term_ready_en)) else $error("dtr lag");
    AST_TD_GRANT: assert property (!td_out |-> rts_out && dtr_out) else $error("frame without grant");
    AST_FLOW_GATE: assert property ($fell(td_out) && $past(flow_gate_en) |->
        $past(line_level[SMCH_IDX_CTS]) && $past(line_level[SMCH_IDX_DSR])) else $error("start while gated");
    AST_RTS_RISE: assert property ($rose(rts_out) |-> $past(dtr_out) && tx_busy) else $error("rts early");
    AST_RTS_KEEP: assert property (rts_out && tx_busy |=> rts_out) else $error("rts dropped busy");
    AST_RTS_HOLD: assert property ($fell(rts_out) |-> $past(idle_cnt) >= HOLD_CYC - 1) else $error("rts short");
    AST_SYNC: assert property (age == 3 |-> line_level == $past(ctrl_in, 3)) else $error("sync latency");
    AST_CHANGE: assert property (age == 3 |->
        line_change == (line_level ^ $past(line_level))) else $error("change flag");
endmodule
bind smch_dte smch_chk #(.HOLD_CYC(HOLD_CYC)) i_chk (
    .clock(clock), .sys_rst(sys_rst), .term_ready_en(term_ready_en), .flow_gate_en(flow_gate_en),
    .cts_in(cts_in), .dsr_in(dsr_in), .dcd_in(dcd_in), .ri_in(ri_in), .rts_out(rts_out),
    .dtr_out(dtr_out), .td_out(td_out), .line_level(line_level), .line_change(line_change),
    .tx_busy(tx_busy));
`default_nettype wire

// ---- testbench/smch_dte_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module smch_dte_tb;
    import smch_pkg::*;
    logic       clock, sys_rst, term_ready_en, flow_gate_en, tx_valid, tx_ready, ri_in;
    logic       carrier, half_duplex, link_down, rts_out, dtr_out, td_out, tx_busy, cts_in, dsr_in, dcd_in;
    logic       null_modem, rd;
    logic [7:0] tx_data;
    logic [3:0] line_level, dly;
    int         miscompares, samples_checked;
    smch_dte #(.BIT_DIV(4), .HOLD_CYC(3)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .term_ready_en(term_ready_en),
        .flow_gate_en(flow_gate_en), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .cts_in(cts_in), .dsr_in(dsr_in), .dcd_in(dcd_in), .ri_in(ri_in), .rts_out(rts_out), .dtr_out(dtr_out),
        .td_out(td_out), .line_level(line_level), .line_change(), .tx_busy(tx_busy));
    smch_dce_model #(.BIT_DIV(4)) i_dce (
        .clock(clock), .sys_rst(sys_rst), .rts(rts_out), .dtr(dtr_out), .td(td_out), .carrier(carrier),
        .half_duplex(half_duplex), .link_down(link_down), .cts_dly(dly), .null_modem(null_modem),
        .cts(cts_in), .dsr(dsr_in), .dcd(dcd_in), .rd(rd));
    always #4 clock = ~clock;
    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic bail();
        miscompares++;
        close_out();
    endtask
    // Leaves valid up so back-to-back words need no idle edge
    task automatic put(input logic [7:0] d);
        int k;
        tx_data <= d;
        tx_valid <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge clock);
            if (tx_ready === 1'b1) break;
        end
        if (k == 200) bail();
    endtask
    task automatic expect_rx(input logic [7:0] d);
        int k;
        for (k = 0; k < 400 && i_dce.rx_q.size() == 0; k++) @(posedge clock);
        if (k == 400) begin
            bail();
        end else begin
            chk(i_dce.rx_q.pop_front(), {1'b1, d});
        end
    endtask
    task automatic t_lines();
        chk(9'({rts_out, dtr_out, td_out, rd}), 9'h003);
        term_ready_en <= 1'b1;
        tick(8);
        chk(9'({dtr_out, line_level}), 9'h012);
        carrier <= 1'b1;
        ri_in <= 1'b1;
        tick(5);
        chk(9'(line_level), 9'h00E);
        ri_in <= 1'b0;
    endtask
    task automatic t_gate();
        link_down <= 1'b1;
        tick(10);
        put(8'h5A);
        put(8'hC3);
        tx_valid <= 1'b0;
        tick(40);
        chk(9'({tx_ready, td_out, rts_out}), 9'h003);
        flow_gate_en <= 1'b0;
        expect_rx(8'h5A);
        expect_rx(8'hC3);
        tick(20);
        flow_gate_en <= 1'b1;
        link_down <= 1'b0;
    endtask
    task automatic t_send();
        dly <= 4'h6;
        put(8'hA5);
        put(8'h3C);
        put(8'h81);
        tx_valid <= 1'b0;
        expect_rx(8'hA5);
        chk(9'({rts_out, line_level[SMCH_IDX_DCD]}), 9'h002);
        expect_rx(8'h3C);
        expect_rx(8'h81);
        tick(20);
        chk(9'({rts_out, td_out, tx_busy}), 9'h002);
    endtask
    task automatic t_null();
        null_modem <= 1'b1;
        put(8'h96);
        tx_valid <= 1'b0;
        expect_rx(8'h96);
        tick(20);
        chk(9'({rts_out, line_level[SMCH_IDX_CTS]}), 9'h000);
        null_modem <= 1'b0;
    endtask
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {term_ready_en, tx_valid, ri_in, carrier, link_down, null_modem} = '0;
        flow_gate_en = 1'b1;
        half_duplex = 1'b1;
        tx_data = 8'h00;
        dly = 4'h1;
        miscompares = 0;
        samples_checked = 0;
        tick(2);
        sys_rst <= 1'b0;
        tick(3);
        t_lines();
        t_gate();
        t_send();
        t_null();
        close_out();
    end
endmodule
`default_nettype wire
